// [hdl/arpc_pkg.sv]
package arpc_pkg;
    // ========================================
    // Host port map
    localparam int HOST_DATA_W = 8;
    localparam int HOST_ADDR_W = 5;
    localparam logic [4:0] ADDR_VIEW0 = 5'h00;
    localparam logic [4:0] ADDR_VIEW1 = 5'h01;
    localparam logic [4:0] ADDR_SYS_CTRL = 5'h02;
    localparam logic [4:0] ADDR_SP_CTRL = 5'h03;
    localparam logic [4:0] ADDR_MEM_BASE = 5'h04;
    localparam int MEM_BYTES = 28;
    // ========================================
    // System control fields
    localparam int SYS_VIEW_BIT = 0;
    localparam int SYS_MODE_LSB = 1;
    localparam int SYS_MODE_MSB = 2;
    localparam int SYS_REPEAT_BIT = 3;
    localparam logic [1:0] BUF_MODE_RSVD = 2'h3;
    // ========================================
    // Serial port control fields
    localparam int SP_EDGE_BIT = 0;
    localparam int SP_MASTER_BIT = 1;
    localparam int SP_FS_SRC_BIT = 2;
    localparam int SP_FS_2X_BIT = 3;
    // ========================================
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] IEN_RST = 8'h00;
    // ========================================
    // Clock ratios
    localparam int MCK_PER_SCK = 4;
    localparam int SCK_PER_SAMPLE = 32;
    localparam int MCK_PER_FS = 256;
    localparam int SAMPLE_W = 24;
    localparam int SLOT_W = 32;
    // ========================================
    // Carriers
    typedef struct packed {
        logic csN;
        logic rdWr;
        logic [HOST_ADDR_W-1:0] addr;
        logic [HOST_DATA_W-1:0] wdata;
    } arpc_host_req_t;
    typedef struct packed {
        logic [SAMPLE_W-1:0] data;
        logic err;
    } arpc_sample_t;
    typedef struct packed {
        logic we;
        logic [HOST_ADDR_W-1:0] addr;
        logic [HOST_DATA_W-1:0] data;
    } arpc_mem_wr_t;
    typedef struct packed {
        logic val;
        logic oe;
    } arpc_pin_t;
endpackage

// [hdl/arpc_mem.sv]
`timescale 1ns/1ps
module arpc_mem #(
    parameter int DEPTH = arpc_pkg::MEM_BYTES,
    parameter int W = arpc_pkg::HOST_DATA_W
) (
    input wire logic clock,
    input wire logic rst,
    input arpc_pkg::arpc_mem_wr_t hostWr,
    input arpc_pkg::arpc_mem_wr_t devWr,
    input wire logic [arpc_pkg::HOST_ADDR_W-1:0] rdAddr,
    output logic [W-1:0] rdData
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] cells;
        logic [W-1:0] rdData;
    } arpc_mem_state_t;

    arpc_mem_state_t q_ff;
    arpc_mem_state_t nxt_q;

    // ========================================
    // Device write wins a same-address clash
    always_comb begin
        nxt_q = q_ff;
        if (hostWr.we && (int'(hostWr.addr) < DEPTH)) begin
            nxt_q.cells[hostWr.addr] = hostWr.data;
        end
        if (devWr.we && (int'(devWr.addr) < DEPTH)) begin
            nxt_q.cells[devWr.addr] = devWr.data;
        end
        nxt_q.rdData = (int'(rdAddr) < DEPTH) ? q_ff.cells[rdAddr] : '0;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign rdData = q_ff.rdData;
endmodule

// [hdl/arpc_top.sv]
// Function
// - Bit clock is master clock over 4, frame sync over 256 or 128.
// - Master bit clock toggles from a divide-by-four of master clock ticks.
// - Master mode with divided frame sync gives exactly 32 bit clock periods per audio sample.
// - Master select drives bit clock and frame sync, otherwise both are inputs.
// - Edge select one: data changes falling edge; zero: changes rising edge.
// - Frame sync comes from master clock division or stream-extracted edges.
// - Host port reaches status, enables, controls and 28-byte buffer memory.
// - Status and enable pairs share addresses 0 and 1, chosen by view bit.
// - Select low with write level stores bus data at the address.
// - Select low with read level drives addressed data, then releases bus.
// - Two-bit field picks one of three buffer memory organisations.
// - Optional repeat of previous sample when the sample carries an error.
// - View bit zero shows status at 0 and 1, one shows enables.
// - Reset clears control and enable registers.
`timescale 1ns/1ps
module arpc_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic recoveredMasterClock,
    input wire logic streamFrameSync,
    input wire logic sckIn,
    input wire logic frameSyncIn,
    output arpc_pkg::arpc_pin_t sckPin,
    output arpc_pkg::arpc_pin_t frameSyncPin,
    output logic serialData,
    input wire logic sampleValid,
    input arpc_pkg::arpc_sample_t sampleIn,
    output logic sampleReady,
    input arpc_pkg::arpc_host_req_t hostReq,
    output logic [arpc_pkg::HOST_DATA_W-1:0] hostDataOut,
    output logic hostDataOe,
    input wire logic [7:0] statusIn1,
    input wire logic [7:0] statusIn2,
    input arpc_pkg::arpc_mem_wr_t devMemWr,
    output logic [1:0] bufferMode,
    output logic [7:0] interruptEnable1,
    output logic [7:0] interruptEnable2
);
    typedef struct packed {
        logic [7:0] sysCtrl;
        logic [7:0] spCtrl;
        logic [7:0] ien1;
        logic [7:0] ien2;
        logic mckPrev;
        logic streamPrev;
        logic csPrev;
        logic sckPrev;
        logic fsLast;
        logic [7:0] divCnt;
        logic [arpc_pkg::SLOT_W-1:0] shift;
        logic [arpc_pkg::SAMPLE_W-1:0] lastWord;
        logic [7:0] rdData;
        arpc_pkg::arpc_sample_t [1:0] fifo;
        logic wrPtr;
        logic rdPtr;
        logic [1:0] fill;
    } arpc_top_state_t;

    arpc_top_state_t q_ff;
    arpc_top_state_t nxt_q;
    logic master, edgeSel, fsFromStream, fs2x, repeatOnErr, view;
    logic sckEff, fsEff, mckRise, changeEdge, boundary, csFall, hostWrite, popNow;
    logic [7:0] memRdata;
    logic [4:0] memAddr;
    arpc_pkg::arpc_mem_wr_t hostMemWr;
    arpc_pkg::arpc_sample_t head;

    function automatic logic inMem(input logic [4:0] a);
        return (a >= arpc_pkg::ADDR_MEM_BASE)
            && (int'(a) < int'(arpc_pkg::ADDR_MEM_BASE) + arpc_pkg::MEM_BYTES);
    endfunction

    // ========================================
    // Mode decode
    assign master = q_ff.spCtrl[arpc_pkg::SP_MASTER_BIT];
    assign edgeSel = q_ff.spCtrl[arpc_pkg::SP_EDGE_BIT];
    assign fsFromStream = q_ff.spCtrl[arpc_pkg::SP_FS_SRC_BIT];
    assign fs2x = q_ff.spCtrl[arpc_pkg::SP_FS_2X_BIT];
    assign repeatOnErr = q_ff.sysCtrl[arpc_pkg::SYS_REPEAT_BIT];
    assign view = q_ff.sysCtrl[arpc_pkg::SYS_VIEW_BIT];
    assign mckRise = recoveredMasterClock & ~q_ff.mckPrev;
    assign sckEff = master ? q_ff.divCnt[1] : sckIn;
    assign fsEff = master ? (fs2x ? q_ff.divCnt[6] : q_ff.divCnt[7]) : frameSyncIn;
    assign changeEdge = edgeSel ? (q_ff.sckPrev & ~sckEff) : (~q_ff.sckPrev & sckEff);
    assign boundary = fs2x ? (fsEff & ~q_ff.fsLast) : (fsEff ^ q_ff.fsLast);
    assign head = q_ff.fifo[q_ff.rdPtr];
    assign popNow = changeEdge & boundary & (q_ff.fill != 2'h0);
    assign csFall = ~hostReq.csN & q_ff.csPrev;
    assign hostWrite = csFall & ~hostReq.rdWr;
    assign memAddr = hostReq.addr - arpc_pkg::ADDR_MEM_BASE;
    assign hostMemWr = '{we: hostWrite & inMem(hostReq.addr), addr: memAddr,
        data: hostReq.wdata};

    arpc_mem #(
        .DEPTH(arpc_pkg::MEM_BYTES),
        .W(arpc_pkg::HOST_DATA_W)
    ) u_mem (
        .clock(clock),
        .rst(rst),
        .hostWr(hostMemWr),
        .devWr(devMemWr),
        .rdAddr(memAddr),
        .rdData(memRdata)
    );

    // ========================================
    // Next state
    always_comb begin
        nxt_q = q_ff;
        nxt_q.mckPrev = recoveredMasterClock;
        nxt_q.streamPrev = streamFrameSync;
        nxt_q.csPrev = hostReq.csN;
        nxt_q.sckPrev = sckEff;
        if (mckRise) begin
            nxt_q.divCnt = q_ff.divCnt + 8'h01;
        end
        if (fsFromStream && (streamFrameSync ^ q_ff.streamPrev)) begin
            nxt_q.divCnt = {streamFrameSync, 7'h00};
        end
        if (changeEdge) begin
            nxt_q.fsLast = fsEff;
            if (boundary) begin
                if (q_ff.fill == 2'h0) begin
                    nxt_q.shift = '0;
                end else if (head.err && repeatOnErr) begin
                    nxt_q.shift = {q_ff.lastWord, 8'h00};
                end else begin
                    nxt_q.shift = {head.data, 8'h00};
                    nxt_q.lastWord = head.data;
                end
            end else begin
                nxt_q.shift = {q_ff.shift[arpc_pkg::SLOT_W-2:0], 1'b0};
            end
        end
        if (popNow) begin
            nxt_q.rdPtr = ~q_ff.rdPtr;
        end
        if (sampleValid && (q_ff.fill != 2'h2)) begin
            nxt_q.fifo[q_ff.wrPtr] = sampleIn;
            nxt_q.wrPtr = ~q_ff.wrPtr;
        end
        nxt_q.fill = q_ff.fill + {1'b0, sampleValid && (q_ff.fill != 2'h2)}
            - {1'b0, popNow};
        if (hostWrite) begin
            if (hostReq.addr == arpc_pkg::ADDR_SYS_CTRL) begin
                nxt_q.sysCtrl = hostReq.wdata;
                if (hostReq.wdata[arpc_pkg::SYS_MODE_MSB:arpc_pkg::SYS_MODE_LSB]
                    == arpc_pkg::BUF_MODE_RSVD) begin
                    nxt_q.sysCtrl[arpc_pkg::SYS_MODE_MSB:arpc_pkg::SYS_MODE_LSB] =
                        q_ff.sysCtrl[arpc_pkg::SYS_MODE_MSB:arpc_pkg::SYS_MODE_LSB];
                end
            end else if (hostReq.addr == arpc_pkg::ADDR_SP_CTRL) begin
                nxt_q.spCtrl = hostReq.wdata;
            end else if ((hostReq.addr == arpc_pkg::ADDR_VIEW0) && view) begin
                nxt_q.ien1 = hostReq.wdata;
            end else if ((hostReq.addr == arpc_pkg::ADDR_VIEW1) && view) begin
                nxt_q.ien2 = hostReq.wdata;
            end
        end
        if (inMem(hostReq.addr)) begin
            nxt_q.rdData = memRdata;
        end else if (hostReq.addr == arpc_pkg::ADDR_VIEW0) begin
            nxt_q.rdData = view ? q_ff.ien1 : statusIn1;
        end else if (hostReq.addr == arpc_pkg::ADDR_VIEW1) begin
            nxt_q.rdData = view ? q_ff.ien2 : statusIn2;
        end else if (hostReq.addr == arpc_pkg::ADDR_SYS_CTRL) begin
            nxt_q.rdData = q_ff.sysCtrl;
        end else if (hostReq.addr == arpc_pkg::ADDR_SP_CTRL) begin
            nxt_q.rdData = q_ff.spCtrl;
        end else begin
            nxt_q.rdData = 8'h00;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q_ff <= '0;
            q_ff.sysCtrl <= arpc_pkg::CTRL_RST;
            q_ff.spCtrl <= arpc_pkg::CTRL_RST;
            q_ff.ien1 <= arpc_pkg::IEN_RST;
            q_ff.ien2 <= arpc_pkg::IEN_RST;
            q_ff.csPrev <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ========================================
    // Outputs
    assign sckPin = '{val: q_ff.divCnt[1], oe: master};
    assign frameSyncPin = '{val: fs2x ? q_ff.divCnt[6] : q_ff.divCnt[7], oe: master};
    assign serialData = q_ff.shift[arpc_pkg::SLOT_W-1];
    assign sampleReady = q_ff.fill != 2'h2;
    assign hostDataOut = q_ff.rdData;
    assign hostDataOe = ~hostReq.csN & hostReq.rdWr;
    assign bufferMode = q_ff.sysCtrl[arpc_pkg::SYS_MODE_MSB:arpc_pkg::SYS_MODE_LSB];
    assign interruptEnable1 = q_ff.ien1;
    assign interruptEnable2 = q_ff.ien2;

    // ========================================
    // Checking helpers
    logic [3:0] mckSinceSck_ff;
    logic [8:0] mckSinceFs_ff;
    logic [5:0] bitCnt_ff;
    logic seenSck_ff, seenFs_ff, seenLoad_ff, sckRose, fsRose, plainMaster;
    assign plainMaster = master & ~fsFromStream;
    assign sckRose = sckPin.val & ~q_ff.sckPrev;
    assign fsRose = ~fs2x & q_ff.divCnt[7] & ~q_ff.fsLast & changeEdge;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mckSinceSck_ff <= 4'h0;
            mckSinceFs_ff <= 9'h000;
            bitCnt_ff <= 6'h00;
            seenSck_ff <= 1'b0;
            seenFs_ff <= 1'b0;
            seenLoad_ff <= 1'b0;
        end else if (!plainMaster || (hostWrite && hostReq.addr == arpc_pkg::ADDR_SP_CTRL)) begin
            seenSck_ff <= 1'b0;
            seenFs_ff <= 1'b0;
            seenLoad_ff <= 1'b0;
        end else begin
            mckSinceSck_ff <= sckRose ? {3'h0, mckRise} : mckSinceSck_ff + {3'h0, mckRise};
            mckSinceFs_ff <= fsRose ? {8'h00, mckRise} : mckSinceFs_ff + {8'h00, mckRise};
            seenSck_ff <= seenSck_ff | sckRose;
            seenFs_ff <= seenFs_ff | fsRose;
            if (changeEdge) begin
                bitCnt_ff <= boundary ? 6'h01 : bitCnt_ff + 6'h01;
                seenLoad_ff <= seenLoad_ff | boundary;
            end
        end
    end

    // ========================================
    // Assertions
    a_sck_div_four: assert property (
        @(posedge clock) disable iff (rst)
        plainMaster && seenSck_ff && sckRose |-> mckSinceSck_ff == 4'h4)
        else $error("bit clock period is not four master clocks");
    a_fs_div_256: assert property (
        @(posedge clock) disable iff (rst)
        plainMaster && seenFs_ff && fsRose |-> mckSinceFs_ff == 9'h100)
        else $error("frame sync period is not 256 master clocks");
    a_bits_per_sample: assert property (
        @(posedge clock) disable iff (rst)
        plainMaster && seenLoad_ff && changeEdge && boundary |-> bitCnt_ff == 6'h20)
        else $error("sample slot is not 32 bit clocks");
    a_pin_direction: assert property (
        @(posedge clock) disable iff (rst)
        $rose(q_ff.spCtrl[arpc_pkg::SP_MASTER_BIT]) |-> sckPin.oe && frameSyncPin.oe
        ##1 $past(hostWrite) || (sckPin.oe == frameSyncPin.oe))
        else $error("clock pin drive does not follow master select");
    a_data_edge: assert property (
        @(posedge clock) disable iff (rst)
        $changed(serialData) |-> $past(changeEdge))
        else $error("serial data changed away from its launch edge");
    a_ctrl_store: assert property (
        @(posedge clock) disable iff (rst)
        hostWrite && hostReq.addr == arpc_pkg::ADDR_SP_CTRL |=>
        q_ff.spCtrl == $past(hostReq.wdata))
        else $error("serial port control write not stored");
    a_bus_release: assert property (
        @(posedge clock) disable iff (rst)
        hostReq.csN |-> !hostDataOe)
        else $error("data bus driven without select");
    a_view_select: assert property (
        @(posedge clock) disable iff (rst)
        !hostReq.csN && hostReq.rdWr && hostReq.addr == arpc_pkg::ADDR_VIEW0 |=>
        hostDataOut == ($past(view) ? $past(q_ff.ien1) : $past(statusIn1)))
        else $error("address 0 read shows wrong register pair");
    a_repeat_error: assert property (
        @(posedge clock) disable iff (rst)
        popNow && head.err && repeatOnErr |=>
        q_ff.shift == {$past(q_ff.lastWord), 8'h00} && q_ff.lastWord == $past(q_ff.lastWord))
        else $error("errored sample not replaced by previous one");
endmodule

// [verif/arpc_dsp_model.sv]
`timescale 1ns/1ps
module arpc_dsp_model (
    input wire logic clock,
    input wire logic drive,
    input wire logic edgeSel,
    input wire logic gated,
    input wire logic sckLine,
    input wire logic fsLine,
    input wire logic serialData,
    output logic sckOut,
    output logic fsOut
);
    // ========================================
    // Slave clock source
    logic [31:0] slots[$];
    logic [31:0] shiftReg = 32'h0;
    int badEdge = 0;
    int bitCnt = 0;
    logic sckPrev = 1'b0;
    logic fsPrev = 1'b0;
    logic dataPrev = 1'b0;
    logic launchSeen = 1'b1;
    initial begin
        sckOut = 1'b0;
        fsOut = 1'b0;
        forever begin
            @(posedge clock);
            #1 sckOut = edgeSel;
            if (drive) begin
                for (int i = 0; i < 32; i++) begin
                    @(posedge clock);
                    #1 sckOut = !edgeSel;
                    fsOut = (i == 0) ? !fsOut : fsOut;
                    repeat (gated ? 6 : 10) @(posedge clock);
                    #1 sckOut = edgeSel;
                    repeat (gated ? 5 : 9) @(posedge clock);
                end
                if (gated) repeat (256) @(posedge clock);
            end
        end
    end
    // ========================================
    // Slot capture on the sampling edge
    always @(posedge clock) begin
        if (fsLine !== fsPrev)
            bitCnt = 0;
        if (sckLine !== sckPrev) begin
            launchSeen = (sckLine !== edgeSel);
            if (!launchSeen) begin
                shiftReg = {shiftReg[30:0], serialData};
                bitCnt++;
                if (bitCnt == 32)
                    slots.push_back(shiftReg);
            end
        end
        if (serialData !== dataPrev && !launchSeen)
            badEdge++;
        sckPrev = sckLine;
        fsPrev = fsLine;
        dataPrev = serialData;
    end
endmodule

// [verif/arpc_top_bench.sv]
`timescale 1ns/1ps
module arpc_top_bench;
    // ========================================
    // Stimulus and wiring
    localparam int LIMIT = 60000;
    localparam logic [4:0] SYS = arpc_pkg::ADDR_SYS_CTRL;
    localparam logic [4:0] SPC = arpc_pkg::ADDR_SP_CTRL;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic recovered_master_clock = 1'b0;
    logic streamFs = 1'b0;
    logic sampleValid = 1'b0;
    logic dspDrive = 1'b0;
    logic dspEdge = 1'b1;
    logic dspGated = 1'b0;
    logic sampleReady, serialData, hostDataOe, sckIn, frameSyncIn, dspSck, dspFs;
    arpc_pkg::arpc_sample_t sampleIn = '0;
    arpc_pkg::arpc_host_req_t hostReq = '{1'b1, 1'b0, 5'h00, 8'h00};
    arpc_pkg::arpc_mem_wr_t devMemWr = '0;
    arpc_pkg::arpc_pin_t sckPin, frameSyncPin;
    logic [7:0] hostDataOut, intEn1, intEn2;
    logic [1:0] bufferMode;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int tickCnt = 0;
    int sckTicks = 0, fsTicks = 0, rises = 0, lastSck = 0, lastFs = 0, lastRises = 0;
    logic mckPrev = 1'b0, sckPrev = 1'b0, fsPrev = 1'b0;
    always #10 clock = ~clock;
    assign sckIn = sckPin.oe ? sckPin.val : dspSck;
    assign frameSyncIn = frameSyncPin.oe ? frameSyncPin.val : dspFs;
    arpc_top dut_u (.clock(clock), .rst(rst), .recoveredMasterClock(recovered_master_clock),
        .streamFrameSync(streamFs), .sckIn(sckIn), .frameSyncIn(frameSyncIn),
        .sckPin(sckPin), .frameSyncPin(frameSyncPin), .serialData(serialData),
        .sampleValid(sampleValid), .sampleIn(sampleIn), .sampleReady(sampleReady),
        .hostReq(hostReq), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
        .statusIn1(8'hA5), .statusIn2(8'h3C), .devMemWr(devMemWr),
        .bufferMode(bufferMode), .interruptEnable1(intEn1), .interruptEnable2(intEn2));
    arpc_dsp_model dsp_u (.clock(clock), .drive(dspDrive), .edgeSel(dspEdge),
        .gated(dspGated), .sckLine(sckIn), .fsLine(frameSyncIn),
        .serialData(serialData), .sckOut(dspSck), .fsOut(dspFs));
    // ========================================
    // Master clock, stream sync and measurement
    always @(posedge clock) begin
        if (recovered_master_clock && !mckPrev) begin
            sckTicks++;
            fsTicks++;
        end
        if (sckPin.val && !sckPrev) begin
            lastSck = sckTicks;
            sckTicks = 0;
            rises++;
        end
        if (frameSyncPin.val !== fsPrev) begin
            lastFs = fsTicks;
            fsTicks = 0;
            lastRises = rises;
            rises = 0;
        end
        mckPrev = recovered_master_clock;
        sckPrev = sckPin.val;
        fsPrev = frameSyncPin.val;
        if (cycles == LIMIT) begin
            fail_count++;
            close_out();
        end
        #1;
        cycles++;
        if (cycles % 2 == 0) begin
            recovered_master_clock = ~recovered_master_clock;
            tickCnt += recovered_master_clock;
            if (recovered_master_clock && tickCnt % 128 == 50) streamFs = ~streamFs;
        end
    end
    // ========================================
    // Tasks
    task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hostWrite(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock) #1 hostReq = '{1'b1, 1'b0, a, d};
        @(posedge clock) #1 hostReq.csN = 1'b0;
        @(posedge clock) #1 hostReq.csN = 1'b1;
    endtask
    task automatic hostRead(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clock) #1 hostReq = '{1'b1, 1'b1, a, 8'h00};
        @(posedge clock) #1 hostReq.csN = 1'b0;
        repeat (3) @(posedge clock);
        #1 checkVal(hostDataOe, 1);
        checkVal(hostDataOut, exp);
        hostReq.csN = 1'b1;
        @(posedge clock) #1 checkVal(hostDataOe, 0);
    endtask
    task automatic pushWord(input logic [23:0] d, input logic e);
        int n;
        n = 0;
        sampleIn = '{d, e};
        sampleValid = 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (!sampleReady && n < 2000);
        #1;
    endtask
    task automatic waitFs();
        logic s;
        int n;
        s = frameSyncIn;
        n = 0;
        while (frameSyncIn === s && n < 4000) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask
    task automatic runSerial(input logic [23:0] a, b, c, input logic errB, input logic [23:0] eb);
        logic [31:0] got[$];
        waitFs();
        waitFs();
        #1 dsp_u.slots.delete();
        dsp_u.badEdge = 0;
        pushWord(a, 1'b0);
        pushWord(b, errB);
        checkVal(sampleReady, 0);
        pushWord(c, 1'b0);
        sampleValid = 1'b0;
        for (int i = 0; i < 6000 && dsp_u.slots.size() < 5; i++) @(posedge clock);
        #1;
        foreach (dsp_u.slots[i]) if (dsp_u.slots[i] !== 32'h0) got.push_back(dsp_u.slots[i]);
        checkVal(got[0], {a, 8'h00});
        checkVal(got[1], {eb, 8'h00});
        checkVal(got[2], {c, 8'h00});
        checkVal(dsp_u.badEdge, 0);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ========================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        #1 rst = 1'b0;
        checkVal({bufferMode, intEn1, intEn2}, 0);
        checkVal({sckPin.oe, frameSyncPin.oe}, 0);
        hostRead(arpc_pkg::ADDR_VIEW0, 8'hA5);
        hostRead(arpc_pkg::ADDR_VIEW1, 8'h3C);
        hostRead(SYS, arpc_pkg::CTRL_RST);
        hostRead(SPC, arpc_pkg::CTRL_RST);
        hostWrite(arpc_pkg::ADDR_VIEW0, 8'h11);
        checkVal(intEn1, arpc_pkg::IEN_RST);
        hostWrite(SYS, 8'h01);
        hostWrite(arpc_pkg::ADDR_VIEW0, 8'h81);
        hostWrite(arpc_pkg::ADDR_VIEW1, 8'h1F);
        checkVal({intEn1, intEn2}, 16'h811F);
        hostRead(arpc_pkg::ADDR_VIEW0, 8'h81);
        hostRead(arpc_pkg::ADDR_VIEW1, 8'h1F);
        hostWrite(SYS, 8'h00);
        hostRead(arpc_pkg::ADDR_VIEW0, 8'hA5);
        for (int i = 0; i < 28; i += 9) hostWrite(5'(4 + i), 8'(8'hC0 + i));
        for (int i = 0; i < 28; i += 9) hostRead(5'(4 + i), 8'(8'hC0 + i));
        devMemWr = '{1'b1, 5'h05, 8'h5A};
        @(posedge clock) #1 devMemWr = '0;
        hostRead(5'h09, 8'h5A);
        for (int m = 0; m < 3; m++) begin
            hostWrite(SYS, 8'(m << 1));
            checkVal(bufferMode, m);
        end
        hostWrite(SYS, 8'h0E);
        checkVal(bufferMode, 2);
        hostRead(SYS, 8'h0C);
        hostWrite(SYS, 8'h00);
        hostWrite(SPC, 8'h03);
        checkVal({sckPin.oe, frameSyncPin.oe}, 2'h3);
        repeat (2200) @(posedge clock);
        checkVal(lastSck, 4);
        checkVal(lastFs, 128);
        checkVal(lastRises, 32);
        runSerial(24'h9A5C31, 24'h80F00F, 24'hC3A596, 1'b0, 24'h80F00F);
        hostWrite(SPC, 8'h0B);
        repeat (1200) @(posedge clock);
        checkVal(lastFs, 64);
        hostWrite(SPC, 8'h07);
        repeat (2) begin
            @(streamFs);
            repeat (160) @(posedge clock);
            #1 checkVal(frameSyncPin.val, streamFs);
        end
        dspDrive = 1'b1;
        hostWrite(SPC, 8'h01);
        checkVal({sckPin.oe, frameSyncPin.oe}, 0);
        runSerial(24'hF1E2D3, 24'h8C4B2A, 24'hA1B2C3, 1'b0, 24'h8C4B2A);
        dspEdge = 1'b0;
        dspGated = 1'b1;
        hostWrite(SPC, 8'h00);
        runSerial(24'hB4C3D2, 24'h9E8D7C, 24'hE5F607, 1'b0, 24'h9E8D7C);
        hostWrite(SYS, 8'h08);
        runSerial(24'hD00DAD, 24'h812345, 24'hCAFE01, 1'b1, 24'hD00DAD);
        close_out();
    end
endmodule
